// [rtl/dac_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if
  import dac_link_pkg::*;
();
  logic                update_clk;
  logic [SAMPLE_W-1:0] sample_word;
  logic                pd_out;
  logic                pd_oe;
  logic                pd_pin;

  // the pull-down wins whenever nobody drives the power-down wire
  assign pd_pin = pd_oe ? pd_out : 1'b0;

  modport source
  (
    output update_clk,
    output sample_word,
    output pd_out,
    output pd_oe
  );

  modport device
  (
    input  update_clk,
    input  sample_word,
    input  pd_pin
  );
endinterface
`default_nettype wire

// [rtl/dac_link_pkg.sv]
// Notes on behaviour
// - sample word: 12 bits, unsigned binary, msb highest
// - all ones steers full scale to true
// - master-slave latch, code changes only at edge
// - output updates after each rising update edge
// - update clock never above 125 MSPS
// - any duty cycle meeting minimum pulse width
// - source changes data on falling edge
// - keep data transitions away from rising edge
// - power-down input pulled low when left floating
// - power-down high turns output current off
// - down within 50 ns, wake after 5 us
// - codes 0..4095, complement is 4095 minus code
package dac_link_pkg;

  // sample word format
  localparam int              SAMPLE_W = 12;
  localparam logic [11:0]     CODE_MAX = 12'h0fff;
  localparam logic [11:0]     CODE_ZERO = 12'h0000;

  // system clock
  localparam int              SYS_PERIOD_NS = 10;

  // update rate ceiling and the cycles it allows
  localparam int              MAX_RATE_MSPS = 125;
  localparam int              MIN_UPDATE_PERIOD_NS = 1000 / MAX_RATE_MSPS;
  localparam int              MIN_UPDATE_CYCLES =
    (MIN_UPDATE_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // source clock phases, each at least one cycle wide
  localparam int              HALF_CNT_W = 4;
  localparam logic [3:0]      UPDATE_HALF_CYCLES = 4'h2;
  localparam logic [3:0]      HALF_CNT_ONE = 4'h1;
  localparam logic [3:0]      HALF_CNT_ZERO = 4'h0;

  // power-down timing
  localparam int              PD_TIME_NS = 50;
  localparam int              PD_CYCLES_INT = (PD_TIME_NS / SYS_PERIOD_NS < 1) ? 1 :
                                              PD_TIME_NS / SYS_PERIOD_NS;
  localparam int              WAKE_TIME_US = 5;
  localparam int              WAKE_CYCLES_INT = (WAKE_TIME_US * 1000) / SYS_PERIOD_NS;
  localparam int              WAKE_CNT_W = 10;
  localparam logic [9:0]      PD_CYCLES = PD_CYCLES_INT[9:0];
  localparam logic [9:0]      WAKE_CYCLES = WAKE_CYCLES_INT[9:0];
  localparam logic [9:0]      WAKE_CNT_ZERO = 10'h000;
  localparam logic [9:0]      WAKE_CNT_ONE = 10'h001;

  // sample buffer in the source
  localparam int              FIFO_DEPTH = 4;

  // sample counter width on the device side
  localparam int              SAMPLE_CNT_W = 16;
  localparam logic [15:0]     SAMPLE_CNT_ONE = 16'h0001;
  localparam logic [15:0]     SAMPLE_CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_STOPPING,
    PWR_DOWN,
    PWR_WAKING
  } power_state_t;

endpackage

// [rtl/dac_sample_input.sv]
`timescale 1ns/1ps
`default_nettype none
module dac_sample_input
  import dac_link_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  dac_link_if.device                 link,
  output logic [SAMPLE_W-1:0]        true_current_out,
  output logic [SAMPLE_W-1:0]        complement_current_out,
  output logic                       sample_update,
  output logic                       full_scale,
  output logic                       converting,
  output logic                       powered_down,
  output logic [SAMPLE_CNT_W-1:0]    sample_count
);
  // latch stage
  logic [SAMPLE_W-1:0]     master_reg;
  logic [SAMPLE_W-1:0]     master_next;
  logic [SAMPLE_W-1:0]     slave_reg;
  logic [SAMPLE_W-1:0]     slave_next;
  logic                    clk_prev_reg;
  logic                    loaded_reg;
  logic                    loaded_next;
  logic                    rise;

  // power control
  power_state_t            state_reg;
  power_state_t            state_next;
  logic [WAKE_CNT_W-1:0]   cnt_reg;
  logic [WAKE_CNT_W-1:0]   cnt_next;

  // output stage
  logic [SAMPLE_W-1:0]     true_reg;
  logic [SAMPLE_W-1:0]     true_next;
  logic [SAMPLE_W-1:0]     comp_reg;
  logic [SAMPLE_W-1:0]     comp_next;
  logic                    update_reg;
  logic                    update_next;
  logic                    full_reg;
  logic                    full_next;
  logic                    conv_reg;
  logic                    conv_next;
  logic                    down_reg;
  logic                    down_next;
  logic [SAMPLE_CNT_W-1:0] count_reg;
  logic [SAMPLE_CNT_W-1:0] count_next;
  logic                    active;

  // a rising edge seen against the previous pin level; each clock phase
  // must last one system cycle, so the rate seen here is capped by it
  assign rise = link.update_clk && !clk_prev_reg;

  // master follows the data only while the clock is low,
  // slave takes the master at the rising edge
  always_comb
  begin
    master_next = master_reg;
    slave_next  = slave_reg;
    loaded_next = loaded_reg;
    if (!link.update_clk)
    begin
      master_next = link.sample_word;
    end
    if (rise)
    begin
      slave_next  = master_reg;
      loaded_next = 1'b1;
    end
  end

  // the latch itself has no reset; its content is meaningless until
  // the first rising edge, which loaded_reg tracks
  always_ff @(posedge sys_clk)
  begin
    master_reg <= master_next;
    slave_reg  <= slave_next;                  // held between edges
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      clk_prev_reg <= 1'b0;
      loaded_reg   <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= link.update_clk;
      loaded_reg   <= loaded_next;
    end
  end

  // power sequencing: a high level stops the current at once, the
  // powered-down flag follows within the stop time; release waits
  // out the wake time before current flows again
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      PWR_ACTIVE:
      begin
        if (link.pd_pin)
        begin
          state_next = PWR_STOPPING;
          cnt_next   = WAKE_CNT_ONE;
        end
      end
      PWR_STOPPING:
      begin
        cnt_next = cnt_reg + WAKE_CNT_ONE;
        if (cnt_reg >= PD_CYCLES - WAKE_CNT_ONE)
        begin
          state_next = PWR_DOWN;
        end
      end
      PWR_DOWN:
      begin
        if (!link.pd_pin)
        begin
          state_next = PWR_WAKING;
          cnt_next   = WAKE_CNT_ONE;
        end
      end
      PWR_WAKING:
      begin
        cnt_next = cnt_reg + WAKE_CNT_ONE;
        if (link.pd_pin)
        begin
          state_next = PWR_STOPPING;
          cnt_next   = WAKE_CNT_ONE;
        end
        else if (cnt_reg >= WAKE_CYCLES - WAKE_CNT_ONE)
        begin
          state_next = PWR_ACTIVE;
        end
      end
      default:
      begin
        state_next = PWR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_reg <= PWR_ACTIVE;
      cnt_reg   <= WAKE_CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // the power-down level is looked at directly so current stops on the
  // first cycle of a request, not after the state change
  assign active = (state_reg == PWR_ACTIVE) && !link.pd_pin && loaded_reg;

  // code to current split; the true share is code over full scale and
  // the complement the rest, so while active the two sum to the code maximum
  always_comb
  begin
    true_next   = CODE_ZERO;
    comp_next   = CODE_ZERO;
    full_next   = 1'b0;
    update_next = rise && active;
    count_next  = count_reg;
    if (active)
    begin
      true_next = slave_next;
      comp_next = CODE_MAX - slave_next;
      full_next = (slave_next == CODE_MAX);
    end
    if (update_next)
    begin
      count_next = count_reg + SAMPLE_CNT_ONE;
    end
    conv_next = (state_next == PWR_ACTIVE) && !link.pd_pin;
    down_next = (state_next == PWR_DOWN);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      true_reg   <= CODE_ZERO;
      comp_reg   <= CODE_ZERO;
      full_reg   <= 1'b0;
      update_reg <= 1'b0;
      count_reg  <= SAMPLE_CNT_ZERO;
      conv_reg   <= 1'b0;
      down_reg   <= 1'b0;
    end
    else
    begin
      true_reg   <= true_next;
      comp_reg   <= comp_next;
      full_reg   <= full_next;
      update_reg <= update_next;
      count_reg  <= count_next;
      conv_reg   <= conv_next;
      down_reg   <= down_next;
    end
  end

  // every output is a flip-flop
  assign true_current_out       = true_reg;
  assign complement_current_out = comp_reg;
  assign full_scale             = full_reg;
  assign sample_update          = update_reg;
  assign sample_count           = count_reg;
  assign converting             = conv_reg;
  assign powered_down           = down_reg;
endmodule
`default_nettype wire

// [rtl/sample_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
)
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = DEPTH[CNT_W-1:0];
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             push;
  logic             pop;

  // honest full and empty straight from the occupancy count
  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update, wrapping at any depth
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [rtl/sample_source.sv]
`timescale 1ns/1ps
`default_nettype none
module sample_source
  import dac_link_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  dac_link_if.source               link,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  input  wire logic                sample_valid,
  output logic                     sample_ready,
  input  wire logic                pd_request,
  output logic                     link_ready
);
  logic [SAMPLE_W-1:0]   fifo_data;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic                  clk_reg;
  logic                  clk_next;
  logic [HALF_CNT_W-1:0] half_reg;
  logic [HALF_CNT_W-1:0] half_next;
  logic [SAMPLE_W-1:0]   word_reg;
  logic [SAMPLE_W-1:0]   word_next;
  logic                  pd_out_reg;
  logic                  pd_oe_reg;
  logic [WAKE_CNT_W-1:0] wake_reg;
  logic [WAKE_CNT_W-1:0] wake_next;
  logic                  ready_reg;
  logic                  ready_next;
  logic                  fall_tick;

  // ready on the filling side is the buffer's own, so producers stall
  sample_fifo
  #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // falling edge of the update clock is the only launch point
  assign fall_tick = clk_reg && (half_reg == HALF_CNT_ONE);
  assign fifo_pop  = fall_tick && ready_reg && fifo_valid;

  // divider: equal high and low phases, period well above the ceiling
  always_comb
  begin
    clk_next  = clk_reg;
    half_next = half_reg - HALF_CNT_ONE;
    if (half_reg == HALF_CNT_ONE)
    begin
      clk_next  = !clk_reg;                    // 50% duty
      half_next = UPDATE_HALF_CYCLES;
    end
    word_next = word_reg;
    if (fifo_pop)
    begin
      word_next = fifo_data;
    end
  end

  // wait out the wake time after releasing power-down
  always_comb
  begin
    wake_next  = wake_reg;
    ready_next = ready_reg;
    if (pd_request)
    begin
      wake_next  = WAKE_CNT_ZERO;
      ready_next = 1'b0;
    end
    else if (!ready_reg)
    begin
      wake_next = wake_reg + WAKE_CNT_ONE;
      if (wake_reg == WAKE_CYCLES - WAKE_CNT_ONE)
      begin
        ready_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      clk_reg    <= 1'b0;
      half_reg   <= UPDATE_HALF_CYCLES;
      word_reg   <= CODE_ZERO;
      pd_out_reg <= 1'b0;
      pd_oe_reg  <= 1'b0;
      wake_reg   <= WAKE_CNT_ZERO;
      ready_reg  <= 1'b1;
    end
    else
    begin
      clk_reg    <= clk_next;
      half_reg   <= half_next;
      word_reg   <= word_next;
      pd_out_reg <= pd_request;
      pd_oe_reg  <= pd_request;                // float when idle
      wake_reg   <= wake_next;
      ready_reg  <= ready_next;
    end
  end

  assign link.update_clk  = clk_reg;
  assign link.sample_word = word_reg;
  assign link.pd_out      = pd_out_reg;
  assign link.pd_oe       = pd_oe_reg;
  assign link_ready       = ready_reg;
endmodule
`default_nettype wire

// [test/link_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module link_asserts
  import dac_link_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                update_clk,
  input  wire logic [SAMPLE_W-1:0] sample_word,
  input  wire logic                pd_out,
  input  wire logic                pd_oe,
  input  wire logic                pd_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // words move only together with the falling update edge
  word_on_fall_a: assert property (
    $changed(sample_word) |-> $fell(update_clk))
    else $error("word moved away from the falling edge");
  // high phase is exactly two cycles wide
  high_width_a: assert property (
    $rose(update_clk) |-> update_clk [*2] ##1 !update_clk)
    else $error("update clock high phase wrong");
  // low phase of two cycles keeps the rate under the ceiling
  update_rate_a: assert property (
    $fell(update_clk) |-> !update_clk [*2] ##1 update_clk)
    else $error("update clock low phase wrong");
  // data stays clear of the rising edge on both sides
  hold_rise_a: assert property (
    $rose(update_clk) |-> $stable(sample_word) [*2])
    else $error("word moved near the rising edge");
  // pull-down holds the wire low when undriven
  pd_float_a: assert property (
    !pd_oe |-> !pd_pin)
    else $error("floating power-down wire not low");
  // the source only drives the wire to request power-down
  pd_level_a: assert property (
    pd_oe |-> pd_out && pd_pin)
    else $error("driven power-down wire not high");
  // no new words are sent into a powered-down device
  pd_hold_a: assert property (
    pd_pin && $past(pd_pin) |-> $stable(sample_word))
    else $error("word moved during power-down");
  // release lets the wire drop in the same cycle
  pd_release_a: assert property (
    $fell(pd_oe) |-> !pd_pin)
    else $error("power-down wire stuck after release");
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dac_link_pkg::*;
;
  logic                    sys_clk, nrst, sample_valid, pd_request;
  logic                    sample_ready, link_ready, sample_update;
  logic                    full_scale, converting, powered_down;
  logic [SAMPLE_W-1:0]     sample_data, true_out, comp_out, cur;
  logic [SAMPLE_CNT_W-1:0] sample_count, pulse_cnt;
  logic [SAMPLE_W-1:0]     exp_q[$];
  int                      fails, total_checks, cycles, refused;

  dac_link_if link ();

  sample_source u_sample_source (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .pd_request(pd_request), .link_ready(link_ready));

  dac_sample_input u_dac_sample_input (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .true_current_out(true_out), .complement_current_out(comp_out),
    .sample_update(sample_update), .full_scale(full_scale), .converting(converting),
    .powered_down(powered_down), .sample_count(sample_count));

  link_asserts u_link_asserts (.sys_clk(sys_clk), .nrst(nrst),
    .update_clk(link.update_clk), .sample_word(link.sample_word),
    .pd_out(link.pd_out), .pd_oe(link.pd_oe), .pd_pin(link.pd_pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard sized well above the longest wake sequence
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end

  // every update pulse is judged; a new code takes the next queued word
  always @(posedge sys_clk)
    if (nrst === 1'b1 && sample_update === 1'b1)
    begin
      pulse_cnt = pulse_cnt + 16'h0001;
      if (true_out !== cur)
        cur = exp_q.size() ? exp_q.pop_front() : ~cur;
      check(16'(true_out), 16'(cur));
      check(16'(comp_out), 16'(CODE_MAX - cur));
      check(16'(full_scale), 16'(cur == CODE_MAX));
      check(16'(converting), 16'h0001);
    end

  // valid stays up across back-to-back pushes; waits while full
  task automatic push(input logic [SAMPLE_W-1:0] w);
    int n;
    n = 0;
    sample_data <= w;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    while (sample_ready !== 1'b1 && n < 200)
    begin
      refused++;
      n++;
      @(posedge sys_clk);
    end
    exp_q.push_back(w);
  endtask

  task automatic drain;
    int n;
    n = 0;
    sample_valid <= 1'b0;
    while ((exp_q.size() != 0 || n < 12) && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    check(16'(exp_q.size()), 16'h0000);
  endtask

  task automatic wait_down(output int n);
    n = 0;
    while (powered_down !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic reset_test;
    @(negedge sys_clk);
    check(16'(true_out), 16'(CODE_ZERO));
    check(16'(comp_out), 16'(CODE_ZERO));
    check(16'(sample_ready), 16'h0001);
    check(16'(link_ready), 16'h0001);
    @(posedge sys_clk);
  endtask

  // six words against a four-deep buffer forces a refusal; msb, lsb and ends
  task automatic stream_test;
    logic [SAMPLE_W-1:0] codes [6];
    codes = '{12'h0fff, 12'h0001, 12'h0800, 12'h0a5c, 12'h0000, 12'h07ff};
    refused = 0;
    foreach (codes[i])
      push(codes[i]);
    check(16'(refused != 0), 16'h0001);
    drain();
  endtask

  // power-down, a wake cut short, then a full wake and fresh data
  task automatic pd_test;
    int n;
    pd_request <= 1'b1;
    wait_down(n);
    check(16'(n <= PD_CYCLES + 2), 16'h0001);
    @(negedge sys_clk);
    check(16'(true_out), 16'(CODE_ZERO));
    check(16'(comp_out), 16'(CODE_ZERO));
    check(16'(converting), 16'h0000);
    check(16'(link_ready), 16'h0000);
    check(sample_count, pulse_cnt);
    @(posedge sys_clk);
    pd_request <= 1'b0;
    repeat (100) @(posedge sys_clk);
    check(16'(converting), 16'h0000);
    pd_request <= 1'b1;
    wait_down(n);
    check(16'(n <= PD_CYCLES + 2), 16'h0001);
    pd_request <= 1'b0;
    n = 0;
    while (converting !== 1'b1 && n < 700)
    begin
      @(posedge sys_clk);
      n++;
    end
    check(16'(n >= WAKE_CYCLES && n <= WAKE_CYCLES + 12), 16'h0001);
    push(12'h0123);
    drain();
  endtask

  initial
  begin
    nrst <= 1'b0;
    sample_valid <= 1'b0;
    sample_data <= CODE_ZERO;
    pd_request <= 1'b0;
    cur = CODE_ZERO;
    pulse_cnt = SAMPLE_CNT_ZERO;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    reset_test();
    stream_test();
    pd_test();
    test_done();
  end
endmodule
`default_nettype wire
